/* File: common/sram_host_pkg.sv */
/*
 * Constants for the host-side controller of an asynchronous 16-bit static memory.
 * Assumes a 125 MHz system clock; all pin timing counts are derived here.
 */
package sram_host_pkg;
	// Geometry
	localparam int ADDR_W      = 21;           // Word address width
	localparam int DATA_W      = 16;           // Data bus width
	localparam int LANE_W      = 8;            // One byte lane
	localparam int LANES       = 2;            // Lanes per word
	// Clock
	localparam int CLK_PERIOD_PS = 8000;       // 125 MHz
	// Times in ns, as printed
	localparam int T_READ_NS   = 55;           // Read cycle / address to data valid
	localparam int T_WRITE_NS  = 40;           // Write window width
	localparam int T_SETUP_NS  = 25;           // Data setup to write end
	localparam int T_TURN_NS   = 20;           // Bus release after strobe
	// Cycle counts; least times round up
	localparam int RD_CYC      = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WR_CYC      = (T_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_CYC   = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TURN_CYC    = (T_TURN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W       = 4;            // Width of the phase counter
	// Controller states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_WRITE = 3'b010,
		ST_HOLD  = 3'b011,
		ST_TURN  = 3'b100
	} state_e;
endpackage : sram_host_pkg

/* File: hw/phase_timer.sv */
/*
 * Loadable down-counter that flags when a phase has run its cycles.
 * Assumes load and the count come from logic on the same clock.
 */
`timescale 1ns/1ps
module phase_timer #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] cnt_q; // Cycles still to run

	// Reload on request, else count down to zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Done when at one, so the phase spans exactly the loaded count.
	// Load is kept out of this term: the caller reloads on done, and a
	// term on load here would close a combinational loop through it.
	assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule : phase_timer

/* File: hw/sram_host_ctrl.sv */
/*
 * Host controller driving an asynchronous 16-bit static memory with byte lanes.
 * Assumes user requests come from logic on clk; memory data pins are returned
 * through two flip-flops before use.
 */
// What this block does
// - Write window is overlap of all strobes
// - Data held across the ending edge
// - Host releases bus while memory drives
// - Selects always held at valid levels
`timescale 1ns/1ps
module sram_host_ctrl
	import sram_host_pkg::*;
#(
	parameter int AW = sram_host_pkg::ADDR_W
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// User request side
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic                        req_write,
	input  wire logic [AW-1:0]               req_addr,
	input  wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
	input  wire logic [sram_host_pkg::LANES-1:0]  req_lanes,
	output logic                             rsp_valid,
	output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
	// Memory pins
	output logic [AW-1:0]                    mem_addr,
	output logic                             chip_select_a_n,
	output logic                             chip_select_b,
	output logic                             write_strobe_n,
	output logic                             output_enable_n,
	output logic                             upper_byte_select_n,
	output logic                             lower_byte_select_n,
	input  wire logic [sram_host_pkg::DATA_W-1:0] mem_dq_in,
	output logic [sram_host_pkg::DATA_W-1:0] mem_dq_out,
	output logic [sram_host_pkg::DATA_W-1:0] mem_dq_oe
);
	import sram_host_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State and pin registers
	state_e                state_q, state_d;   // Controller state
	logic [AW-1:0]         addr_q;             // Latched word address
	logic [DATA_W-1:0]     wdata_q;            // Latched write data
	logic [LANES-1:0]      lanes_q;            // Latched lane enables, bit1 upper
	logic                  sel_q;              // Chip selected
	logic                  we_q;               // Write strobe active
	logic                  oe_q;               // Memory output enable active
	logic                  drive_q;            // Host driving data pins
	logic [DATA_W-1:0]     dq_s1_q, dq_s2_q;   // Data pin synchroniser
	logic [DATA_W-1:0]     rdata_q;            // Captured read data
	logic                  rsp_q;              // Response pulse
	logic                  tmr_load;           // Start a phase
	logic [CNT_W-1:0]      tmr_count;          // Phase length
	logic                  tmr_done;           // Phase over
	logic                  take;               // Request accepted
	logic                  lanes_any;          // Some lane requested

	////////////////////////////////////////////////////////////////////////
	// Decode
	assign lanes_any = |req_lanes;
	// Empty lane set is dropped: it would only deselect the memory
	assign take      = (state_q == ST_IDLE) && req_valid;
	assign req_ready = (state_q == ST_IDLE);

	// Phase lengths: read waits access time plus two sync stages
	assign tmr_count = (state_q == ST_IDLE && !req_write) ? CNT_W'(RD_CYC + 2) :
	                   (state_q == ST_IDLE)               ? CNT_W'(WR_CYC) :
	                                                        CNT_W'(TURN_CYC);
	assign tmr_load  = (take && lanes_any) || (tmr_done && state_q != ST_TURN);

	phase_timer #(.W(CNT_W)) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (tmr_load),
		.count (tmr_count),
		.done  (tmr_done)
	);

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (take && lanes_any) begin
					state_d = req_write ? ST_WRITE : ST_READ;
				end
			end
			ST_READ:  if (tmr_done) state_d = ST_TURN;
			ST_WRITE: if (tmr_done) state_d = ST_HOLD;
			ST_HOLD:  state_d = ST_TURN;
			ST_TURN:  if (tmr_done) state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) state_q <= ST_IDLE;
		else        state_q <= state_d;
	end

	// Latch request; address and lanes stay steady for the whole access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q  <= '0;
			wdata_q <= '0;
			lanes_q <= '0;
		end else if (take && lanes_any) begin
			addr_q  <= req_addr;
			wdata_q <= req_wdata;
			lanes_q <= req_lanes;
		end
	end

	// Pin controls; selects always at a defined level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q   <= 1'b0;
			we_q    <= 1'b0;
			oe_q    <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			// Chip stays selected through read and write, released at turnaround
			sel_q   <= (state_d == ST_READ) || (state_d == ST_WRITE) || (state_d == ST_HOLD);
			// Strobe alone closes the window; selects drop one cycle later
			we_q    <= (state_d == ST_WRITE);
			oe_q    <= (state_d == ST_READ);
			// Data held through HOLD so it outlasts the closing edge
			drive_q <= (state_d == ST_WRITE) || (state_d == ST_HOLD);
		end
	end

	// Pins
	assign mem_addr            = addr_q;
	assign chip_select_a_n     = !sel_q;
	assign chip_select_b       = sel_q;
	assign write_strobe_n      = !we_q;
	assign output_enable_n     = !oe_q;
	assign upper_byte_select_n = !(sel_q && lanes_q[1]);
	assign lower_byte_select_n = !(sel_q && lanes_q[0]);
	assign mem_dq_out          = wdata_q;
	// Never drive while the memory may drive; read owns the bus
	assign mem_dq_oe           = (drive_q && !oe_q) ? {DATA_W{1'b1}} : '0;

	////////////////////////////////////////////////////////////////////////
	// Read return path: two flops before any use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			dq_s1_q <= mem_dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// Capture at the end of the read phase; unselected lanes read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
			rsp_q   <= 1'b0;
		end else begin
			rsp_q <= (state_q == ST_READ && tmr_done) ||
			         (state_q == ST_HOLD) || (take && !lanes_any);
			if (state_q == ST_READ && tmr_done) begin
				rdata_q <= dq_s2_q & {{LANE_W{lanes_q[1]}}, {LANE_W{lanes_q[0]}}};
			end
		end
	end

	// Response and data leave straight from their flops
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Watched at the pins: the memory drives when selected, strobe high, output on
	a_no_bus_fight: assert property (@(posedge clk) disable iff (!rst_n)
		(mem_dq_oe != '0) |-> output_enable_n || chip_select_a_n || !write_strobe_n)
		else $error("host drives while memory may drive");
	// Deselect never leaves the strobe or host data behind
	a_desel_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(chip_select_a_n) |-> write_strobe_n && (mem_dq_oe == '0))
		else $error("deselect with strobe or data active");
	a_we_needs_sel: assert property (@(posedge clk) disable iff (!rst_n)
		!write_strobe_n |-> (!chip_select_a_n && chip_select_b
		&& !(upper_byte_select_n && lower_byte_select_n))) else $error("strobe without select");
	a_we_width: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
		else $error("write window wrong length");
	a_data_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(write_strobe_n) |-> (mem_dq_oe != '0) && $stable(mem_dq_out))
		else $error("data not held past window close");
	a_sel_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(write_strobe_n) |-> !chip_select_a_n) else $error("select left with strobe");
	a_oe_we_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(oe_q && we_q)) else $error("read and write strobes together");
	a_idle_desel: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == ST_IDLE) |-> chip_select_a_n && !chip_select_b && write_strobe_n)
		else $error("memory selected while idle");
	a_read_rsp: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(oe_q) |-> ##[8:10] rsp_valid) else $error("read answer late");
	c_read:  cover property (@(posedge clk) disable iff (!rst_n) $rose(oe_q) ##[1:12] rsp_valid);
	c_write: cover property (@(posedge clk) disable iff (!rst_n) $rose(we_q));
	c_empty: cover property (@(posedge clk) disable iff (!rst_n) take && !lanes_any);
	c_upper: cover property (@(posedge clk) disable iff (!rst_n)
		!upper_byte_select_n && lower_byte_select_n);
endmodule : sram_host_ctrl

/* File: verification/async_sram_byte_lane_access_bench.sv */
/* Self-checking bench for the static memory host controller.
 * Assumes sram_model on the memory pins and a 125 MHz clock. */
`timescale 1ns/1ps
module async_sram_byte_lane_access_bench;
	import sram_host_pkg::*;
	////////////////////////////////////////////////////////////////
	logic              clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = 21'h000000;
	logic [DATA_W-1:0] req_wdata = 16'h0000;
	logic [1:0]        req_lanes = 2'h0;
	logic              req_ready, rsp_valid, fault;
	logic [DATA_W-1:0] rsp_rdata, mem_dq_in, mem_dq_out, mem_dq_oe;
	logic [ADDR_W-1:0] mem_addr;
	logic              chip_select_a_n, chip_select_b, write_strobe_n;
	logic              output_enable_n, upper_byte_select_n, lower_byte_select_n;
	int                error_cnt = 0, tests_run = 0, lat;
	always #4 clk = ~clk;
	sram_host_ctrl uut (.clk, .rst_n, .req_valid, .req_ready, .req_write, .req_addr,
		.req_wdata, .req_lanes, .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_a_n,
		.chip_select_b, .write_strobe_n, .output_enable_n, .upper_byte_select_n,
		.lower_byte_select_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
	sram_model mem_m (.addr(mem_addr), .chip_select_a_n, .chip_select_b, .write_strobe_n,
		.output_enable_n, .upper_byte_select_n, .lower_byte_select_n,
		.host_dq(mem_dq_out), .host_oe(mem_dq_oe), .dq(mem_dq_in), .fault);
	////////////////////////////////////////////////////////////////
	task automatic chk_data(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask : chk_data
	task automatic chk_bit(string what, logic exp, logic got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %b got %b", what, exp, got);
		end
	endtask : chk_bit
	// One request; lat counts edges from take to the response
	task automatic access(logic wr, logic [ADDR_W-1:0] a, logic [1:0] ln, logic [DATA_W-1:0] d);
		int n;
		n = 0;
		// Always let one edge pass, so a dropped request is seen low first
		do begin
			@(posedge clk);
			#1 n++;
		end while (req_ready !== 1'b1 && n < 40);
		{req_valid, req_write, req_addr, req_lanes, req_wdata} = {1'b1, wr, a, ln, d};
		@(posedge clk);
		#1 req_valid = 1'b0;
		lat = 0;
		while (rsp_valid !== 1'b1 && lat < 40) begin
			@(posedge clk);
			#1 lat++;
		end
		chk_bit("rsp_valid", 1'b1, rsp_valid);
	endtask : access
	////////////////////////////////////////////////////////////////
	// Pins parked at firm deselect levels after reset
	task automatic t_idle;
		chk_data("idle pins", 16'h002f, {10'h000, chip_select_a_n, chip_select_b,
			write_strobe_n, output_enable_n, upper_byte_select_n, lower_byte_select_n});
		chk_data("idle oe", 16'h0000, mem_dq_oe);
	endtask : t_idle
	// Full word at the top address, write then read
	task automatic t_full;
		access(1'b1, 21'h1fffff, 2'h3, 16'hc3a5);
		chk_data("write latency", 16'(WR_CYC + 1), lat[15:0]);
		access(1'b0, 21'h1fffff, 2'h3, 16'h0000);
		chk_data("top word", 16'hc3a5, rsp_rdata);
	endtask : t_full
	// Upper lane write must leave the lower lane alone
	task automatic t_lane_write;
		access(1'b1, 21'h000000, 2'h3, 16'h1234);
		access(1'b1, 21'h000000, 2'h2, 16'habcd);
		access(1'b0, 21'h000000, 2'h3, 16'h0000);
		chk_data("merged word", 16'hab34, rsp_rdata);
	endtask : t_lane_write
	// Single lane reads return zero in the unselected lane
	task automatic t_lane_read;
		access(1'b0, 21'h000000, 2'h1, 16'h0000);
		chk_data("low lane", 16'h0034, rsp_rdata);
		access(1'b0, 21'h000000, 2'h2, 16'h0000);
		chk_data("high lane", 16'hab00, rsp_rdata);
	endtask : t_lane_read
	// No lanes means deselect: quick answer, nothing stored
	task automatic t_empty;
		access(1'b1, 21'h000000, 2'h0, 16'hffff);
		chk_data("empty latency", 16'h0000, lat[15:0]);
		access(1'b0, 21'h000000, 2'h3, 16'h0000);
		chk_data("after empty", 16'hab34, rsp_rdata);
	endtask : t_empty
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		t_idle();
		t_full();
		t_lane_write();
		t_lane_read();
		t_empty();
		chk_bit("bus clash", 1'b0, fault);
		close_out();
	end
	// Watchdog: a few hundred cycles are enough for all accesses
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		close_out();
	end
endmodule : async_sram_byte_lane_access_bench

/* File: verification/sram_model.sv */
/* Behavioural static memory with two byte lanes, seen from its pins.
 * Assumes the host splits each data pin into a value and an enable. */
`timescale 1ns/1ps
module sram_model (
	input  wire logic [sram_host_pkg::ADDR_W-1:0] addr,
	input  wire logic                             chip_select_a_n,
	input  wire logic                             chip_select_b,
	input  wire logic                             write_strobe_n,
	input  wire logic                             output_enable_n,
	input  wire logic                             upper_byte_select_n,
	input  wire logic                             lower_byte_select_n,
	input  wire logic [sram_host_pkg::DATA_W-1:0] host_dq,
	input  wire logic [sram_host_pkg::DATA_W-1:0] host_oe,
	output logic [sram_host_pkg::DATA_W-1:0]      dq,
	output logic                                  fault
);
	import sram_host_pkg::*;
	////////////////////////////////////////////////////////////////
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Sparse word store
	logic [DATA_W-1:0] word;                     // Word being merged
	logic [DATA_W-1:0] junk = 16'h5a5a;          // Floating pins wander
	logic [DATA_W-1:0] rd;                       // Stored word at addr
	logic              ub, lb;                   // Lane enables
	int                wr_seen = 0;              // Bumped on every store, wakes the read side
	assign ub = !upper_byte_select_n;
	assign lb = !lower_byte_select_n;
	// Selected only with both chips on and a lane on
	wire sel = !chip_select_a_n && chip_select_b && (ub || lb);
	wire wr  = sel && !write_strobe_n;
	wire rdo = sel && write_strobe_n && !output_enable_n;
	wire [DATA_W-1:0] drv = {{8{rdo && ub}}, {8{rdo && lb}}};
	// Released pins must not hold a value the host could trust
	always #3 junk = ~junk;
	always @(addr, wr_seen) rd = mem.exists(addr) ? mem[addr] : ~junk;
	assign dq = (host_dq & host_oe) | (rd & drv) | (junk & ~host_oe & ~drv);
	// Last data seen while the window is open is what stays
	// So host data only counts if it is valid at the closing edge
	always @(wr, addr, host_dq, ub, lb) begin
		if (wr) begin
			word = mem.exists(addr) ? mem[addr] : 16'h0000;
			if (ub) word[15:8] = host_dq[15:8];
			if (lb) word[7:0] = host_dq[7:0];
			mem[addr] = word;
			wr_seen++;
		end
	end
	// Sticky flag when both ends drive one pin
	initial fault = 1'b0;
	always @(host_oe, drv) if (|(host_oe & drv)) fault = 1'b1;
endmodule : sram_model
